// [rtl/rrs_pkg.sv]
package rrs_pkg;
    localparam int RRS_DATA_W = 8;
    localparam int RRS_PC_W = 13;
    localparam int RRS_STACK_DEPTH = 16;
    localparam int RRS_RET_CYCLES = 2;
    localparam int RRS_SKIP_CYCLES = 2;
    localparam logic RRS_GIE_RESET = 1'b0;
    localparam logic RRS_GIE_ON = 1'b1;
    localparam logic [7:0] RRS_ACC_RESET = 8'h00;
    localparam logic [3:0] RRS_FLAGS_RESET = 4'h0;
    // Flag vector positions
    localparam int RRS_FLAG_C = 0;
    localparam int RRS_FLAG_AC = 1;
    localparam int RRS_FLAG_Z = 2;
    localparam int RRS_FLAG_OV = 3;

    typedef enum logic [3:0] {
        RRS_OP_NONE,
        RRS_OP_SUBROUTINE_RETURN,
        RRS_OP_RETURN_LITERAL,
        RRS_OP_INTERRUPT_RETURN,
        RRS_OP_ROTATE_LEFT_MEM,
        RRS_OP_ROTATE_LEFT_TO_ACC,
        RRS_OP_ROTATE_LEFT_CARRY_MEM,
        RRS_OP_ROTATE_LEFT_CARRY_TO_ACC,
        RRS_OP_ROTATE_RIGHT_MEM,
        RRS_OP_ROTATE_RIGHT_TO_ACC,
        RRS_OP_ROTATE_RIGHT_CARRY_MEM,
        RRS_OP_ROTATE_RIGHT_CARRY_TO_ACC,
        RRS_OP_SUBTRACT_WITH_BORROW,
        RRS_OP_SUBTRACT_WITH_BORROW_TO_MEM,
        RRS_OP_DECREMENT_SKIP_ZERO,
        RRS_OP_DECREMENT_SKIP_ZERO_TO_ACC
    } rrs_op_t;
endpackage

// [rtl/rrs_stack_mem.sv]
`timescale 1ns/1ps
module rrs_stack_mem
    import rrs_pkg::*;
#(
    parameter int WIDTH = RRS_PC_W,
    parameter int DEPTH = RRS_STACK_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Elaboration check: a one-entry stack cannot hold a nested return
    if (DEPTH < 2 || AW != $clog2(DEPTH)) begin : g_bad_depth
        $error("rrs_stack_mem: DEPTH must be at least 2 and AW must match it");
    end

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// [rtl/rrs_exec.sv]
`timescale 1ns/1ps
module rrs_exec
    import rrs_pkg::*;
#(
    parameter int PC_W = RRS_PC_W,
    parameter int STACK_DEPTH = RRS_STACK_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire rrs_op_t op_code,
    input wire logic [7:0] op_imm,
    input wire logic [7:0] mem_rdata,
    input wire logic push_en,
    input wire logic [PC_W-1:0] push_pc,
    output logic op_ready,
    output logic [7:0] acc_q,
    output logic [3:0] flags_q,
    output logic gie_q,
    output logic [PC_W-1:0] pc_load,
    output logic pc_load_en,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic skip_next
);
    localparam int AW = $clog2(STACK_DEPTH);

    // Pointer wraps by width, so only power-of-two depths are served
    if (PC_W < 1 || STACK_DEPTH < 2 || (1 << AW) != STACK_DEPTH) begin : g_bad_params
        $error("rrs_exec: STACK_DEPTH must be a power of two, PC_W positive");
    end

    typedef enum logic [1:0] {RRS_ST_IDLE, RRS_ST_POP, RRS_ST_DUMMY} rrs_state_t;

    function automatic logic [8:0] rrs_rot(input logic [7:0] v, input logic left, input logic thru_c,
                                           input logic cin);
        logic in_bit;
        in_bit = thru_c ? cin : (left ? v[7] : v[0]);
        if (left) begin
            rrs_rot = {v[7], v[6:0], in_bit};
        end else begin
            rrs_rot = {v[0], in_bit, v[7:1]};
        end
    endfunction

    rrs_state_t state_q, state_d;
    logic [7:0] acc_d;
    logic [3:0] flags_d;
    logic gie_d;
    logic [AW-1:0] sp_q, sp_d;
    logic [PC_W-1:0] pc_load_d;
    logic pc_load_en_d, skip_d, mem_we_d;
    logic [7:0] mem_wdata_d;
    logic [PC_W-1:0] top_pc;
    logic [8:0] rot;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] dec;
    logic take;

    assign take = op_valid && state_q == RRS_ST_IDLE;
    assign op_ready = state_q == RRS_ST_IDLE;

    rrs_stack_mem #(.WIDTH(PC_W), .DEPTH(STACK_DEPTH), .AW(AW)) u_stack (
        .mclk(mclk),
        .wr_en(push_en),
        .wr_addr(sp_q),
        .wr_data(push_pc),
        .rd_addr(AW'(sp_q - 1'b1)),
        .rd_data(top_pc)
    );

    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        flags_d = flags_q;
        gie_d = gie_q;
        sp_d = push_en ? AW'(sp_q + 1'b1) : sp_q;
        pc_load_d = pc_load;
        pc_load_en_d = 1'b0;
        skip_d = 1'b0;
        mem_we_d = 1'b0;
        mem_wdata_d = mem_wdata;
        rot = 9'h000;
        sum = {1'b0, acc_q} + {1'b0, ~mem_rdata} + {8'h00, flags_q[RRS_FLAG_C]};
        nib = {1'b0, acc_q[3:0]} + {1'b0, ~mem_rdata[3:0]} + {4'h0, flags_q[RRS_FLAG_C]};
        dec = mem_rdata - 8'h01;
        case (state_q)
            RRS_ST_IDLE: begin
                if (take) begin
                    case (op_code)
                        RRS_OP_SUBROUTINE_RETURN, RRS_OP_RETURN_LITERAL, RRS_OP_INTERRUPT_RETURN: begin
                            // Stack read is registered, so PC lands in the second cycle
                            state_d = RRS_ST_POP;
                            if (op_code == RRS_OP_RETURN_LITERAL) begin
                                acc_d = op_imm;
                            end
                            if (op_code == RRS_OP_INTERRUPT_RETURN) begin
                                gie_d = RRS_GIE_ON;
                            end
                        end
                        RRS_OP_ROTATE_LEFT_MEM, RRS_OP_ROTATE_LEFT_TO_ACC, RRS_OP_ROTATE_LEFT_CARRY_MEM,
                        RRS_OP_ROTATE_LEFT_CARRY_TO_ACC, RRS_OP_ROTATE_RIGHT_MEM, RRS_OP_ROTATE_RIGHT_TO_ACC,
                        RRS_OP_ROTATE_RIGHT_CARRY_MEM, RRS_OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
                            rot = rrs_rot(mem_rdata,
                                op_code inside {RRS_OP_ROTATE_LEFT_MEM, RRS_OP_ROTATE_LEFT_TO_ACC,
                                    RRS_OP_ROTATE_LEFT_CARRY_MEM, RRS_OP_ROTATE_LEFT_CARRY_TO_ACC},
                                op_code inside {RRS_OP_ROTATE_LEFT_CARRY_MEM, RRS_OP_ROTATE_LEFT_CARRY_TO_ACC,
                                    RRS_OP_ROTATE_RIGHT_CARRY_MEM, RRS_OP_ROTATE_RIGHT_CARRY_TO_ACC},
                                flags_q[RRS_FLAG_C]);
                            if (op_code inside {RRS_OP_ROTATE_LEFT_CARRY_MEM, RRS_OP_ROTATE_LEFT_CARRY_TO_ACC,
                                    RRS_OP_ROTATE_RIGHT_CARRY_MEM, RRS_OP_ROTATE_RIGHT_CARRY_TO_ACC}) begin
                                flags_d[RRS_FLAG_C] = rot[8];
                            end
                            if (op_code inside {RRS_OP_ROTATE_LEFT_TO_ACC, RRS_OP_ROTATE_LEFT_CARRY_TO_ACC,
                                    RRS_OP_ROTATE_RIGHT_TO_ACC, RRS_OP_ROTATE_RIGHT_CARRY_TO_ACC}) begin
                                acc_d = rot[7:0];
                            end else begin
                                mem_we_d = 1'b1;
                                mem_wdata_d = rot[7:0];
                            end
                        end
                        RRS_OP_SUBTRACT_WITH_BORROW, RRS_OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
                            flags_d[RRS_FLAG_C] = sum[8];
                            flags_d[RRS_FLAG_AC] = nib[4];
                            flags_d[RRS_FLAG_Z] = sum[7:0] == 8'h00;
                            flags_d[RRS_FLAG_OV] = (acc_q[7] != mem_rdata[7]) && (sum[7] != acc_q[7]);
                            if (op_code == RRS_OP_SUBTRACT_WITH_BORROW) begin
                                acc_d = sum[7:0];
                            end else begin
                                mem_we_d = 1'b1;
                                mem_wdata_d = sum[7:0];
                            end
                        end
                        RRS_OP_DECREMENT_SKIP_ZERO, RRS_OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
                            if (op_code == RRS_OP_DECREMENT_SKIP_ZERO) begin
                                mem_we_d = 1'b1;
                                mem_wdata_d = dec;
                            end else begin
                                acc_d = dec;
                            end
                            if (dec == 8'h00) begin
                                skip_d = 1'b1;
                                state_d = RRS_ST_DUMMY;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            RRS_ST_POP: begin
                // A push in the same cycle is not expected during a return
                pc_load_d = top_pc;
                pc_load_en_d = 1'b1;
                sp_d = AW'(sp_q - 1'b1);
                state_d = RRS_ST_IDLE;
            end
            RRS_ST_DUMMY: begin
                state_d = RRS_ST_IDLE;
            end
            default: begin
                state_d = RRS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= RRS_ST_IDLE;
            acc_q <= RRS_ACC_RESET;
            flags_q <= RRS_FLAGS_RESET;
            gie_q <= RRS_GIE_RESET;
            sp_q <= '0;
            pc_load <= '0;
            pc_load_en <= 1'b0;
            skip_next <= 1'b0;
            mem_we <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            flags_q <= flags_d;
            gie_q <= gie_d;
            sp_q <= sp_d;
            pc_load <= pc_load_d;
            pc_load_en <= pc_load_en_d;
            skip_next <= skip_d;
            mem_we <= mem_we_d;
            mem_wdata <= mem_wdata_d;
        end
    end

    chk_ret_two_cycles: assert property (@(posedge mclk) disable iff (!rst_b)
        take && op_code == RRS_OP_SUBROUTINE_RETURN |-> ##2 pc_load_en && $stable(flags_q))
        else $error("return did not load pc in two cycles");
    chk_ret_literal_acc: assert property (@(posedge mclk) disable iff (!rst_b)
        take && op_code == RRS_OP_RETURN_LITERAL |=> acc_q == $past(op_imm))
        else $error("return literal did not load acc");
    chk_interrupt_return_sets_gie: assert property (@(posedge mclk) disable iff (!rst_b)
        take && op_code == RRS_OP_INTERRUPT_RETURN |=> gie_q ##1 pc_load_en)
        else $error("interrupt return did not enable interrupts");
    chk_rotl_mem: assert property (@(posedge mclk) disable iff (!rst_b)
        take && op_code == RRS_OP_ROTATE_LEFT_MEM |=> mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
        else $error("rotate left memory wrong");
    chk_rotl_acc: assert property (@(posedge mclk) disable iff (!rst_b)
        take && op_code == RRS_OP_ROTATE_LEFT_TO_ACC |=> !mem_we && acc_q == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
        else $error("rotate left to acc wrong");
    chk_rotlc_carry: assert property (@(posedge mclk) disable iff (!rst_b)
        take && op_code == RRS_OP_ROTATE_LEFT_CARRY_MEM |=> flags_q[0] == $past(mem_rdata[7]) && mem_wdata[0] == $past(flags_q[0]))
        else $error("rotate left carry wrong");
    chk_rotrc_carry: assert property (@(posedge mclk) disable iff (!rst_b)
        take && op_code == RRS_OP_ROTATE_RIGHT_CARRY_MEM |=> flags_q[0] == $past(mem_rdata[0]) && mem_wdata[7] == $past(flags_q[0]))
        else $error("rotate right carry wrong");
    chk_rotr_acc: assert property (@(posedge mclk) disable iff (!rst_b)
        take && op_code == RRS_OP_ROTATE_RIGHT_TO_ACC |=> !mem_we && acc_q == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
        else $error("rotate right to acc wrong");
    chk_rotr_mem: assert property (@(posedge mclk) disable iff (!rst_b)
        take && op_code == RRS_OP_ROTATE_RIGHT_MEM |=> mem_we && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
        else $error("rotate right memory wrong");
    chk_rotlc_acc: assert property (@(posedge mclk) disable iff (!rst_b)
        take && op_code == RRS_OP_ROTATE_LEFT_CARRY_TO_ACC |=> !mem_we && flags_q[0] == $past(mem_rdata[7])
            && acc_q == {$past(mem_rdata[6:0]), $past(flags_q[0])})
        else $error("rotate left carry to acc wrong");
    chk_dec_skip: assert property (@(posedge mclk) disable iff (!rst_b)
        take && op_code == RRS_OP_DECREMENT_SKIP_ZERO && mem_rdata == 8'h01 |=> skip_next && !op_ready ##1 op_ready)
        else $error("decrement skip did not skip");
endmodule

// [test/rrs_exec_tb.sv]
`timescale 1ns/1ps
module rrs_exec_tb;
    import rrs_pkg::*;
    logic mclk, rst_b, op_valid, push_en;
    rrs_op_t op_code;
    logic [7:0] op_imm, mem_rdata;
    logic [RRS_PC_W-1:0] push_pc, pc_load;
    logic op_ready, pc_load_en, mem_we, skip_next, gie_q;
    logic [7:0] acc_q, mem_wdata;
    logic [3:0] flags_q;
    int err_total, num_checks;
    logic [31:0] rng;
    logic [7:0] m_acc;
    logic [3:0] m_flg;
    logic m_gie;
    logic [RRS_PC_W-1:0] stk[$];

    rrs_exec rrs_exec_i(.mclk(mclk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code), .op_imm(op_imm),
        .mem_rdata(mem_rdata), .push_en(push_en), .push_pc(push_pc), .op_ready(op_ready), .acc_q(acc_q),
        .flags_q(flags_q), .gie_q(gie_q), .pc_load(pc_load), .pc_load_en(pc_load_en), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .skip_next(skip_next));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        t = t ^ (t << 5);
        return t;
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic push(input logic [RRS_PC_W-1:0] v);
        @(posedge mclk);
        push_en <= 1'b1;
        push_pc <= v;
        @(posedge mclk);
        push_en <= 1'b0;
        stk.push_back(v);
    endtask

    task automatic run(input rrs_op_t op, input logic [7:0] imm, input logic [7:0] m);
        logic we, sk, busy, c, ret, ov, ac;
        logic [7:0] wd, r, nm;
        logic [RRS_PC_W-1:0] pc;
        int s;
        we = 0; sk = 0; busy = 0; ret = 0; wd = 0; pc = 0; r = 0;
        c = m_flg[RRS_FLAG_C];
        nm = ~m;
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code <= op;
        op_imm <= imm;
        mem_rdata <= m;
        @(posedge mclk);
        case (op)
            RRS_OP_SUBROUTINE_RETURN, RRS_OP_RETURN_LITERAL, RRS_OP_INTERRUPT_RETURN: begin
                ret = 1; busy = 1;
                pc = stk.pop_back();
                if (op == RRS_OP_RETURN_LITERAL) m_acc = imm;
                if (op == RRS_OP_INTERRUPT_RETURN) m_gie = 1'b1;
            end
            RRS_OP_ROTATE_LEFT_MEM: begin we = 1; wd = {m[6:0], m[7]}; end
            RRS_OP_ROTATE_LEFT_TO_ACC: m_acc = {m[6:0], m[7]};
            RRS_OP_ROTATE_LEFT_CARRY_MEM: begin we = 1; wd = {m[6:0], c}; m_flg[RRS_FLAG_C] = m[7]; end
            RRS_OP_ROTATE_LEFT_CARRY_TO_ACC: begin m_acc = {m[6:0], c}; m_flg[RRS_FLAG_C] = m[7]; end
            RRS_OP_ROTATE_RIGHT_MEM: begin we = 1; wd = {m[0], m[7:1]}; end
            RRS_OP_ROTATE_RIGHT_TO_ACC: m_acc = {m[0], m[7:1]};
            RRS_OP_ROTATE_RIGHT_CARRY_MEM: begin we = 1; wd = {c, m[7:1]}; m_flg[RRS_FLAG_C] = m[0]; end
            RRS_OP_ROTATE_RIGHT_CARRY_TO_ACC: begin m_acc = {c, m[7:1]}; m_flg[RRS_FLAG_C] = m[0]; end
            RRS_OP_SUBTRACT_WITH_BORROW, RRS_OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
                s = m_acc + nm + c;
                r = s[7:0];
                ac = (m_acc[3:0] + nm[3:0] + c) > 15;
                ov = (m_acc[7] == nm[7]) && (r[7] != m_acc[7]);
                m_flg = {ov, r == 8'h00, ac, s > 255};
                if (op == RRS_OP_SUBTRACT_WITH_BORROW) m_acc = r;
                else begin we = 1; wd = r; end
            end
            RRS_OP_DECREMENT_SKIP_ZERO, RRS_OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
                r = m - 8'h01;
                sk = (r == 8'h00);
                busy = sk;
                if (op == RRS_OP_DECREMENT_SKIP_ZERO) begin we = 1; wd = r; end
                else m_acc = r;
            end
            default: ;
        endcase
        // Keep a request up through the busy cycle; it must be ignored
        if (busy) op_code <= RRS_OP_ROTATE_LEFT_MEM;
        else op_valid <= 1'b0;
        @(negedge mclk);
        chk("acc", acc_q, m_acc);
        chk("flags", flags_q, m_flg);
        chk("gie", gie_q, m_gie);
        chk("mem_we", mem_we, we);
        if (we) chk("mem_wdata", mem_wdata, wd);
        chk("skip_next", skip_next, sk);
        chk("op_ready", op_ready, !busy);
        chk("pc_load_en", pc_load_en, 1'b0);
        if (busy) begin
            @(posedge mclk);
            op_valid <= 1'b0;
            @(negedge mclk);
            chk("pc_load_en", pc_load_en, ret);
            if (ret) chk("pc_load", pc_load, pc);
            chk("mem_we", mem_we, 1'b0);
            chk("op_ready", op_ready, 1'b1);
        end
    endtask

    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        #(25 * 20000);
        err_total++;
        results;
    end

    initial begin
        int k;
        logic [7:0] m;
        rst_b = 0; op_valid = 0; op_code = RRS_OP_NONE; op_imm = 0; mem_rdata = 0; push_en = 0; push_pc = 0;
        err_total = 0; num_checks = 0; rng = 32'd55462;
        m_acc = RRS_ACC_RESET; m_flg = RRS_FLAGS_RESET; m_gie = RRS_GIE_RESET;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(negedge mclk);
        chk("acc", acc_q, m_acc);
        chk("flags", flags_q, m_flg);
        chk("gie", gie_q, m_gie);
        chk("op_ready", op_ready, 1'b1);
        for (int i = 0; i < 400; i++) begin
            k = i % 16;
            rng = xs(rng);
            m = rng[7:0];
            // Force the zero-result path of the decrements often
            if ((k == 14 || k == 15) && rng[9]) m = 8'h01;
            if (k >= 1 && k <= 3) push(rng[28:16]);
            run(rrs_op_t'(k[3:0]), rng[15:8], m);
        end
        results;
    end
endmodule
